// ---- dv/tb.sv ----
// self-checking bench for the addressable serial receiver
`timescale 1ns/1ps
`default_nettype none

module tb;
  import urx_pkg::*;
  logic clk = 1'b0;
  logic reset = 1'b1;
  urx_req_s req = '0;
  logic [7:0] rdata;
  logic receive_line;
  urx_irq_s irq;
  logic [7:0] v;
  int failures = 0;
  int tests_run = 0;
  int cyc = 0;

  always #4 clk = ~clk;

  urx_receiver urx_receiver_i (.clk(clk), .reset(reset), .req(req),
    .rdata(rdata), .receive_line(receive_line), .irq(irq));
  // divisor 0 with high speed gives sixteen clocks a bit
  urx_node urx_node_i (.clk(clk), .line(receive_line));

  ////////////////////////////////////////////////////////////////////////////
  task automatic finish_test();
    if (failures == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge clk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge clk);
    req.rd <= 1'b0;
    #1 d = rdata;
  endtask : rd

  task automatic rchk(input logic [3:0] a, input logic [7:0] exp);
    logic [7:0] d;
    rd(a, d);
    chk(d, exp);
  endtask : rchk

  // irq packed as high, low, wake
  task automatic ichk(input logic [7:0] exp);
    @(posedge clk);
    #1 chk({5'h00, irq}, exp);
  endtask : ichk

  // generous ceiling; the tests need some three thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    rchk(URX_ADDR_BAUDCTL, 8'h40);
    rchk(URX_ADDR_RXSTAT, 8'h00);
    rchk(4'hC, 8'h00);
    wr(URX_ADDR_TXSTAT, 8'h04);
    wr(URX_ADDR_DIVL, 8'h00);
    wr(URX_ADDR_ENABLES, 8'h20);
    wr(URX_ADDR_PRIO, 8'h20);
    wr(URX_ADDR_INTCTL, 8'h80);
    wr(URX_ADDR_RXSTAT, 8'h90);
    urx_node_i.send(9'h0A5, 8, 1'b1);
    ichk(8'h05);
    wr(URX_ADDR_PRIO, 8'h00);
    ichk(8'h03);
    wr(URX_ADDR_INTCTL, 8'h00);
    ichk(8'h01);
    rchk(URX_ADDR_RXSTAT, 8'h90);
    rchk(URX_ADDR_RXBUF, 8'hA5);
    ichk(8'h00);
    wr(URX_ADDR_INTCTL, 8'h80);
    wr(URX_ADDR_PRIO, 8'h20);
    // nine-bit address detect
    wr(URX_ADDR_RXSTAT, 8'hD8);
    urx_node_i.send(9'h033, 9, 1'b1);
    ichk(8'h00);
    urx_node_i.send(9'h155, 9, 1'b1);
    ichk(8'h05);
    rchk(URX_ADDR_RXSTAT, 8'hD9);
    rchk(URX_ADDR_RXBUF, 8'h55);
    // overrun, then reception halted until the enable is cleared
    wr(URX_ADDR_RXSTAT, 8'h90);
    urx_node_i.send(9'h011, 8, 1'b1);
    urx_node_i.send(9'h022, 8, 1'b1);
    rchk(URX_ADDR_RXSTAT, 8'h92);
    rchk(URX_ADDR_RXBUF, 8'h11);
    urx_node_i.send(9'h033, 8, 1'b1);
    ichk(8'h00);
    wr(URX_ADDR_RXSTAT, 8'h80);
    rchk(URX_ADDR_RXSTAT, 8'h80);
    urx_node_i.send(9'h044, 8, 1'b1);
    ichk(8'h00);
    // framing fault
    wr(URX_ADDR_RXSTAT, 8'h90);
    urx_node_i.send(9'h0FF, 8, 1'b0);
    rchk(URX_ADDR_RXSTAT, 8'h94);
    rd(URX_ADDR_RXBUF, v);
    wr(URX_ADDR_RXSTAT, 8'h80);
    rchk(URX_ADDR_RXSTAT, 8'h80);
    // asleep: no byte reception, but wake on edge still works
    wr(URX_ADDR_RXSTAT, 8'h90);
    wr(URX_ADDR_POWER, 8'h01);
    urx_node_i.send(9'h066, 8, 1'b1);
    ichk(8'h00);
    rchk(URX_ADDR_BAUDCTL, 8'h40);
    wr(URX_ADDR_BAUDCTL, 8'h02);
    rchk(URX_ADDR_BAUDCTL, 8'h42);
    urx_node_i.level(1'b0, 12);
    ichk(8'h05);
    urx_node_i.level(1'b1, 1);
    rchk(URX_ADDR_BAUDCTL, 8'h40);
    rd(URX_ADDR_RXBUF, v);
    ichk(8'h00);
    wr(URX_ADDR_POWER, 8'h00);
    urx_node_i.send(9'h05A, 8, 1'b1);
    rchk(URX_ADDR_RXBUF, 8'h5A);
    // address detect without nine-bit mode drops every character
    wr(URX_ADDR_RXSTAT, 8'h98);
    urx_node_i.send(9'h0FF, 8, 1'b1);
    ichk(8'h00);
    wr(URX_ADDR_RXSTAT, 8'h90);
    // low speed: sixty-four clocks a bit
    wr(URX_ADDR_TXSTAT, 8'h00);
    urx_node_i.bit_cycles = 64;
    urx_node_i.send(9'h0C3, 8, 1'b1);
    rchk(URX_ADDR_RXBUF, 8'hC3);
    // clocked mode: a falling edge must not wake
    wr(URX_ADDR_TXSTAT, 8'h10);
    wr(URX_ADDR_BAUDCTL, 8'h02);
    urx_node_i.level(1'b0, 2);
    ichk(8'h00);
    urx_node_i.level(1'b1, 1);
    rchk(URX_ADDR_BAUDCTL, 8'h42);
    finish_test();
  end
endmodule : tb

bind urx_receiver urx_receiver_chk urx_receiver_chk_i (.clk(clk),
  .reset(reset), .req(req), .rdata(rdata), .receive_line(receive_line),
  .irq(irq));

`default_nettype wire

// ---- dv/urx_node.sv ----
// remote serial node driving the receive line
`timescale 1ns/1ps
`default_nettype none

module urx_node #(
  parameter int BIT_CYCLES = 16
) (
  // clock
  input wire logic clk,
  // serial line, idle high as with a pull-up
  output logic line
);
  // clocks per bit; the bench retimes it when it slows the baud rate
  int bit_cycles = BIT_CYCLES;
  initial line = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // start, data lsb first, stop; a low stop makes a framing fault
  task automatic send(input logic [8:0] d, input int nbits, input logic stop_v);
    int i;
    @(posedge clk);
    line <= 1'b0;
    repeat (bit_cycles) @(posedge clk);
    for (i = 0; i < nbits; i++) begin
      line <= d[i];
      repeat (bit_cycles) @(posedge clk);
    end
    line <= stop_v;
    repeat (bit_cycles) @(posedge clk);
    line <= 1'b1;
  endtask : send

  // hold a level; twelve zero bits form the wake character
  task automatic level(input logic v, input int nbits);
    @(posedge clk);
    line <= v;
    repeat (nbits * bit_cycles) @(posedge clk);
  endtask : level
endmodule : urx_node

`default_nettype wire

// ---- dv/urx_receiver_chk.sv ----
// assertion checker for the addressable serial receiver
`timescale 1ns/1ps
`default_nettype none

module urx_receiver_chk
  import urx_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire urx_pkg::urx_req_s req,
  input wire logic [7:0] rdata,
  // serial line and interrupts
  input wire logic receive_line,
  input wire urx_pkg::urx_irq_s irq
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  ////////////////////////////////////////////////////////////////////////////
  // shadows of the written enables; the core only sees them through irq
  logic gie_q;
  logic prio_q;
  logic en_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      gie_q <= 1'b0;
      prio_q <= 1'b0;
      en_q <= 1'b0;
    end else if (req.wr) begin
      if (req.addr == URX_ADDR_INTCTL) gie_q <= req.wdata[URX_B_GIE];
      if (req.addr == URX_ADDR_PRIO) prio_q <= req.wdata[URX_B_RCF];
      if (req.addr == URX_ADDR_ENABLES) en_q <= req.wdata[URX_B_RCF];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  sequence bad_rd_s;
    req.rd && req.addr > URX_ADDR_POWER;
  endsequence

  rd_slot_a: assert property (!$past(req.rd) |-> rdata == 8'h00)
    else $error("read data outside its slot");
  unmapped_rd_a: assert property (bad_rd_s |=> rdata == 8'h00)
    else $error("unmapped read not zero");
  baud_resv_a: assert property (req.rd && req.addr == URX_ADDR_BAUDCTL
    |=> (rdata & 8'hA5) == 8'h00) else $error("reserved bits not zero");
  irq_excl_a: assert property (!(irq.irq_high && irq.irq_low))
    else $error("both priority lines high");
  irq_high_a: assert property (irq.irq_high |-> gie_q && prio_q && irq.wake)
    else $error("high line without its cause");
  irq_low_a: assert property (irq.irq_low |-> gie_q && !prio_q && irq.wake)
    else $error("low line without its cause");
  irq_route_a: assert property (irq.wake && gie_q |-> irq.irq_high || irq.irq_low)
    else $error("enabled interrupt not routed");
  irq_en_a: assert property (irq.wake |-> en_q)
    else $error("request without local enable");
  flag_fall_a: assert property ($fell(irq.wake) |-> $past(req.rd) || $past(req.wr))
    else $error("request dropped without access");
endmodule : urx_receiver_chk

`default_nettype wire

// ---- hdl/urx_pkg.sv ----
// package for the addressable serial receiver with wake-on-edge
package urx_pkg;

  // register indices on the plain register port
  localparam logic [3:0] URX_ADDR_INTCTL = 4'h0;
  localparam logic [3:0] URX_ADDR_FLAGS = 4'h1;
  localparam logic [3:0] URX_ADDR_ENABLES = 4'h2;
  localparam logic [3:0] URX_ADDR_PRIO = 4'h3;
  localparam logic [3:0] URX_ADDR_RXSTAT = 4'h4;
  localparam logic [3:0] URX_ADDR_RXBUF = 4'h5;
  localparam logic [3:0] URX_ADDR_TXSTAT = 4'h6;
  localparam logic [3:0] URX_ADDR_BAUDCTL = 4'h7;
  localparam logic [3:0] URX_ADDR_DIVH = 4'h8;
  localparam logic [3:0] URX_ADDR_DIVL = 4'h9;
  localparam logic [3:0] URX_ADDR_POWER = 4'hA;

  // field positions
  localparam int URX_B_GIE = 7;
  localparam int URX_B_RCF = 5;
  localparam int URX_B_SERIAL_PORT_ENABLE = 7;
  localparam int URX_B_RX9 = 6;
  localparam int URX_B_CONTINUOUS_RECEIVE_ENABLE = 4;
  localparam int URX_B_ADDRESS_MATCH_ENABLE = 3;
  localparam int URX_B_FRAMING_ERROR_FLAG = 2;
  localparam int URX_B_OVERRUN_ERROR_FLAG = 1;
  localparam int URX_B_NINTH_RECEIVED_BIT = 0;
  localparam int URX_B_SYNC = 4;
  localparam int URX_B_HIGH_SPEED_BAUD_SELECT = 2;
  localparam int URX_B_IDLE = 6;
  localparam int URX_B_WIDE_DIVISOR_SELECT = 3;
  localparam int URX_B_WUE = 1;
  localparam int URX_B_SLEEP = 0;

  // writable masks and reset value
  localparam logic [7:0] URX_BAUDCTL_WMASK = 8'h1A;
  localparam logic [7:0] URX_RXSTAT_WMASK = 8'hF8;
  localparam logic [7:0] URX_RESET_BYTE = 8'h00;

  // oversampling: sixteen ticks per bit, sample at the middle tick
  localparam logic [3:0] URX_TICK_LAST = 4'hF;
  localparam logic [3:0] URX_TICK_MID = 4'h7;

  typedef enum logic [2:0] {
    URX_IDLE, URX_START, URX_DATA, URX_STOP, URX_WAKE_LOW
  } urx_state_e;

  // register port request
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } urx_req_s;

  // interrupt outputs toward the core
  typedef struct packed {
    logic irq_high;
    logic irq_low;
    logic wake;
  } urx_irq_s;

endpackage : urx_pkg

// ---- hdl/urx_receiver.sv ----
// addressable asynchronous serial receiver with wake-on-edge
//
// Behaviour
// RL1 - software clears clocked mode and sets port enable before use
// RL2 - software programs divisor bytes and speed options before reception
// RL3 - nine-bit enable makes characters nine data bits long
// RL4 - address match enable withholds ordinary data characters from buffer
// RL5 - with address match off every character is buffered and flagged
// RL6 - reception only while continuous receive enable is set
// RL7 - complete flag on reception; interrupt needs local and global enable
// RL8 - priority bit routes the receive interrupt high or low
// RL9 - status register shows framing, overrun and ninth received bit
// RL10 - clearing continuous receive enable clears pending receive errors
// RL11 - software compares buffered address byte with its own
// RL12 - unimplemented baud control bits read zero
// RL13 - asleep, the baud generator stops and no byte is received
// RL14 - wake works only in asynchronous mode
// RL15 - wake enable bit turns auto-wake on
// RL16 - with wake enabled, reception stops and receiver watches for edge
// RL17 - falling edge on receive line is the wake event
// RL18 - wake event sets the receive flag, also while asleep
// RL19 - reading the receive buffer clears the receive flag
// RL20 - first rising edge after wake clears wake enable, resumes normal
// RL21 - remote sender's first character must be all zeros
// RL22 - wake character and gap must cover oscillator start-up
// RL23 - frame is start, eight or nine data bits LSB first, stop
// RL24 - line sampled by a sixteen-times-bit-rate shifter
// RL25 - software checks idle flag before setting wake enable
// RL26 - software discards the byte read after a wake event
// RL27 - nine-bit plus address detect buffers only ninth-bit-one chars
// RL28 - overrun when buffer full at completion; reception halts until cleared
`timescale 1ns/1ps
`default_nettype none

module urx_receiver
  import urx_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // register port
  input wire urx_pkg::urx_req_s req,
  output logic [7:0] rdata,
  // serial line
  input wire logic receive_line,
  // interrupt lines toward the core
  output urx_pkg::urx_irq_s irq
);
  import urx_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // software registers
  logic [7:0] intctl_q, enables_q, prio_q, divh_q, divl_q;
  logic serial_port_enable_q, nine_bit_receive_enable_q;
  logic continuous_receive_enable_q, address_match_enable_q;
  logic clocked_mode_q, high_speed_baud_select_q, wide_divisor_select_q;
  logic wake_on_edge_enable_q, sleep_q;
  logic receive_complete_flag_q, framing_error_flag_q, overrun_error_flag_q;
  logic ninth_received_bit_q;
  logic [7:0] receive_buffer_q;
  urx_state_e state_q;
  logic rx_q, rx_prev_q;

  logic wr_stat, rd_buf, async_mode, wake_clear, wake_hit;
  assign wr_stat = req.wr && req.addr == URX_ADDR_RXSTAT;
  assign rd_buf = req.rd && req.addr == URX_ADDR_RXBUF;
  assign async_mode = serial_port_enable_q && !clocked_mode_q;

  // interrupt enables and priority, read back unchanged
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      intctl_q <= URX_RESET_BYTE;
      enables_q <= URX_RESET_BYTE;
      prio_q <= URX_RESET_BYTE;
    end else if (req.wr) begin
      unique case (req.addr)
        URX_ADDR_INTCTL: intctl_q <= req.wdata;
        URX_ADDR_ENABLES: enables_q <= req.wdata;
        URX_ADDR_PRIO: prio_q <= req.wdata;
        default: ;
      endcase
    end
  end

  // baud and mode configuration
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      divh_q <= URX_RESET_BYTE;
      divl_q <= URX_RESET_BYTE;
      clocked_mode_q <= 1'b0;
      high_speed_baud_select_q <= 1'b0;
      wide_divisor_select_q <= 1'b0;
    end else if (req.wr) begin
      unique case (req.addr)
        URX_ADDR_DIVH: divh_q <= req.wdata;
        URX_ADDR_DIVL: divl_q <= req.wdata;
        URX_ADDR_TXSTAT: begin
          clocked_mode_q <= req.wdata[URX_B_SYNC];
          high_speed_baud_select_q <= req.wdata[URX_B_HIGH_SPEED_BAUD_SELECT];
        end
        URX_ADDR_BAUDCTL: wide_divisor_select_q <= req.wdata[URX_B_WIDE_DIVISOR_SELECT];
        default: ;
      endcase
    end
  end

  // sleep stands in for the core's power state; it gates the baud clocks
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      sleep_q <= 1'b0;
    end else if (req.wr && req.addr == URX_ADDR_POWER) begin
      sleep_q <= req.wdata[URX_B_SLEEP];
    end
  end

  // receive control bits all land from one status write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      serial_port_enable_q <= 1'b0;
      nine_bit_receive_enable_q <= 1'b0;
      continuous_receive_enable_q <= 1'b0;
      address_match_enable_q <= 1'b0;
    end else if (wr_stat) begin
      serial_port_enable_q <= req.wdata[URX_B_SERIAL_PORT_ENABLE];
      nine_bit_receive_enable_q <= req.wdata[URX_B_RX9];
      continuous_receive_enable_q <= req.wdata[URX_B_CONTINUOUS_RECEIVE_ENABLE];
      address_match_enable_q <= req.wdata[URX_B_ADDRESS_MATCH_ENABLE];
    end
  end

  // hardware clear on the closing rising edge wins over a software write
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      wake_on_edge_enable_q <= 1'b0;
    end else if (wake_clear) begin
      wake_on_edge_enable_q <= 1'b0; // [RL20]
    end else if (req.wr && req.addr == URX_ADDR_BAUDCTL) begin
      wake_on_edge_enable_q <= req.wdata[URX_B_WUE]; // [RL15]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // baud generator: x16 tick; low speed divides a further four (x64)
  logic [15:0] div_cnt_q, div_top;
  logic [1:0] pre_q;
  logic div_hit, tick, clocks_run;
  assign div_top = wide_divisor_select_q ? {divh_q, divl_q}
                                         : {8'h00, divl_q};
  // no clocks to the port while asleep
  assign clocks_run = async_mode && !sleep_q; // [RL13]
  assign div_hit = clocks_run && div_cnt_q == 16'h0000;
  // low speed: the prescaler advances only when the divider wraps
  assign tick = div_hit && (high_speed_baud_select_q || pre_q == 2'h3);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      div_cnt_q <= 16'h0000;
      pre_q <= 2'h0;
    end else if (!clocks_run) begin
      div_cnt_q <= 16'h0000;
      pre_q <= 2'h0;
    end else if (div_hit) begin
      div_cnt_q <= div_top;
      pre_q <= pre_q + 2'h1;
    end else begin
      div_cnt_q <= div_cnt_q - 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // line sampling and receive state machine
  logic [3:0] os_q;
  logic [3:0] bit_q;
  logic [8:0] shift_q;
  logic rx_fall, rx_rise, mid, frame_done, accept, rx_allowed;
  assign rx_fall = rx_prev_q && !rx_q;
  assign rx_rise = !rx_prev_q && rx_q;
  assign mid = tick && os_q == URX_TICK_MID; // [RL24]
  // an overrun stalls reception until the error is cleared
  assign rx_allowed = continuous_receive_enable_q && !overrun_error_flag_q
                      && !wake_on_edge_enable_q; // [RL6] [RL16] [RL28]
  assign wake_hit = wake_on_edge_enable_q && serial_port_enable_q
                    && !clocked_mode_q && state_q == URX_IDLE
                    && rx_fall; // [RL14] [RL17]
  assign wake_clear = state_q == URX_WAKE_LOW && rx_rise; // [RL20]
  // software polls this before arming wake, so a frame in flight is kept
  logic receiver_idle_flag;
  assign receiver_idle_flag = state_q == URX_IDLE;

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rx_q <= 1'b1;
      rx_prev_q <= 1'b1;
    end else begin
      rx_q <= receive_line;
      rx_prev_q <= rx_q;
    end
  end

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= URX_IDLE;
      os_q <= 4'h0;
      bit_q <= 4'h0;
      shift_q <= 9'h000;
    end else if (wake_hit) begin
      state_q <= URX_WAKE_LOW;
    end else begin
      unique case (state_q)
        URX_IDLE: begin
          os_q <= 4'h0;
          bit_q <= 4'h0;
          if (rx_allowed && clocks_run && !rx_q) begin
            state_q <= URX_START;
          end
        end
        URX_START: begin
          if (tick) begin
            os_q <= os_q + 4'h1;
          end
          // a start bit gone high by mid-bit was a glitch
          if (mid) begin
            state_q <= rx_q ? URX_IDLE : URX_DATA;
            os_q <= URX_TICK_MID + 4'h1;
          end
        end
        URX_DATA: begin
          if (tick) begin
            os_q <= os_q + 4'h1;
          end
          if (mid) begin
            shift_q <= {rx_q, shift_q[8:1]}; // [RL23]
            bit_q <= bit_q + 4'h1;
            if (bit_q == (nine_bit_receive_enable_q ? 4'h8 : 4'h7)) begin
              state_q <= URX_STOP; // [RL3]
            end
          end
        end
        URX_STOP: begin
          if (tick) begin
            os_q <= os_q + 4'h1;
          end
          if (mid) begin
            state_q <= URX_IDLE;
          end
        end
        URX_WAKE_LOW: begin
          if (rx_rise) begin
            state_q <= URX_IDLE;
          end
        end
        default: state_q <= URX_IDLE;
      endcase
      // a cleared receive enable aborts any frame in flight
      if (!continuous_receive_enable_q && state_q != URX_WAKE_LOW) begin
        state_q <= URX_IDLE; // [RL6]
      end
    end
  end

  assign frame_done = state_q == URX_STOP && mid;
  // eight-bit frames leave data in the upper eight of the shifter
  logic [8:0] frame_bits;
  assign frame_bits = nine_bit_receive_enable_q ? shift_q
                                                : {1'b0, shift_q[8:1]};
  // address detect: only ninth-bit-one characters pass
  assign accept = frame_done && (!address_match_enable_q
                  || (nine_bit_receive_enable_q
                      && frame_bits[8])); // [RL4] [RL5] [RL27]

  ////////////////////////////////////////////////////////////////////////////
  // receive buffer and status flags
  // a read in the same cycle as a new frame frees the buffer for it
  logic load_buf;
  assign load_buf = accept && (!receive_complete_flag_q || rd_buf);

  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      receive_buffer_q <= URX_RESET_BYTE;
      ninth_received_bit_q <= 1'b0;
    end else if (load_buf) begin
      receive_buffer_q <= frame_bits[7:0];
      ninth_received_bit_q <= frame_bits[8]; // [RL9]
    end
  end

  // framing fault: stop bit sampled low; rewritten by each loaded frame, cleared when reception is disabled
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      framing_error_flag_q <= 1'b0;
    end else if (load_buf) begin
      framing_error_flag_q <= !rx_q; // [RL9]
    end else if (!continuous_receive_enable_q) begin
      framing_error_flag_q <= 1'b0; // [RL10]
    end
  end

  // set beats the clear by a buffer read in the same cycle
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      receive_complete_flag_q <= 1'b0;
    end else if (accept || wake_hit) begin
      receive_complete_flag_q <= 1'b1; // [RL7] [RL18]
    end else if (rd_buf) begin
      receive_complete_flag_q <= 1'b0; // [RL19]
    end
  end

  // a frame that meets a full buffer is dropped and flags the overrun
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      overrun_error_flag_q <= 1'b0;
    end else if (accept && receive_complete_flag_q && !rd_buf) begin
      overrun_error_flag_q <= 1'b1; // [RL28]
    end else if (!continuous_receive_enable_q) begin
      overrun_error_flag_q <= 1'b0; // [RL10]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt routing
  logic irq_any;
  assign irq_any = receive_complete_flag_q && enables_q[URX_B_RCF]
                   && intctl_q[URX_B_GIE]; // [RL7]
  assign irq.irq_high = irq_any && prio_q[URX_B_RCF]; // [RL8]
  assign irq.irq_low = irq_any && !prio_q[URX_B_RCF]; // [RL8]
  // wake request reaches the core even with the clock gated off in sleep
  assign irq.wake = receive_complete_flag_q && enables_q[URX_B_RCF];

  ////////////////////////////////////////////////////////////////////////////
  // read port: data one cycle after the strobe
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    unique case (req.addr)
      URX_ADDR_INTCTL: rd_mux = intctl_q;
      URX_ADDR_FLAGS: rd_mux = {2'b00, receive_complete_flag_q, 5'b00000};
      URX_ADDR_ENABLES: rd_mux = enables_q;
      URX_ADDR_PRIO: rd_mux = prio_q;
      URX_ADDR_RXSTAT: rd_mux = {serial_port_enable_q,
                                 nine_bit_receive_enable_q, 1'b0,
                                 continuous_receive_enable_q,
                                 address_match_enable_q,
                                 framing_error_flag_q,
                                 overrun_error_flag_q,
                                 ninth_received_bit_q}; // [RL9]
      URX_ADDR_RXBUF: rd_mux = receive_buffer_q;
      URX_ADDR_TXSTAT: rd_mux = {3'b000, clocked_mode_q, 1'b0,
                                 high_speed_baud_select_q, 2'b00};
      URX_ADDR_BAUDCTL: rd_mux = {1'b0, receiver_idle_flag, 1'b0, 1'b0,
                                  wide_divisor_select_q, 1'b0,
                                  wake_on_edge_enable_q, 1'b0}; // [RL12]
      URX_ADDR_DIVH: rd_mux = divh_q;
      URX_ADDR_DIVL: rd_mux = divl_q;
      URX_ADDR_POWER: rd_mux = {7'h00, sleep_q};
      default: rd_mux = 8'h00;
    endcase
  end

  // zero outside the slot, so a stale byte never looks like a fresh read
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rdata <= 8'h00;
    end else if (req.rd) begin
      rdata <= rd_mux;
    end else begin
      rdata <= 8'h00;
    end
  end

endmodule : urx_receiver

`default_nettype wire
